/* File: bcsq_analyzer_model.sv */
// analyzer model: counts the bus states it is told to store
`timescale 1ns/1ps
module bcsq_analyzer_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] status_word,
	output int stored
);
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			stored <= 0;
		end else if (status_word[15]) begin
			stored <= stored + 1;
		end
	end
endmodule : bcsq_analyzer_model

/* File: bcsq_pkg.sv */
// package: status word layout, codes and classification types for the bus status qualifier
package bcsq_pkg;
	localparam int STAT_W = 16;
	localparam int BIT_DIR = 0;
	localparam int BIT_SIZE_LO = 1;
	localparam int BIT_TYPE_LO = 3;
	localparam int BIT_MOD_LO = 5;
	localparam int BIT_ACK = 8;
	localparam int BIT_ERR = 9;
	localparam int BIT_START = 10;
	localparam int BIT_PROG = 11;
	localparam int BIT_GRANT = 12;
	localparam int BIT_LOCK_END = 13;
	localparam int BIT_INT_PEND = 14;
	localparam int BIT_QUAL = 15;
	localparam logic [15:0] STAT_RESET = 16'hFFFF;

	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_LINE = 2'h3;

	typedef enum logic [2:0] {
		BCSQ_QUAL_NORMAL = 3'h1,
		BCSQ_QUAL_MUX = 3'h2,
		BCSQ_QUAL_OFF = 3'h4
	} bcsq_qmode_t;

	typedef enum logic [1:0] {
		BCSQ_SZ_BYTE = 2'h0,
		BCSQ_SZ_WORD = 2'h1,
		BCSQ_SZ_LONG = 2'h2,
		BCSQ_SZ_LINE = 2'h3
	} bcsq_size_t;

	typedef enum logic [3:0] {
		BCSQ_ACC_OTHER = 4'h0,
		BCSQ_ACC_USER_DATA = 4'h1,
		BCSQ_ACC_USER_PROG = 4'h2,
		BCSQ_ACC_SUPER_DATA = 4'h3,
		BCSQ_ACC_SUPER_PROG = 4'h4,
		BCSQ_ACC_CACHE_PUSH = 4'h5,
		BCSQ_ACC_XLAT_DATA = 4'h6,
		BCSQ_ACC_XLAT_PROG = 4'h7,
		BCSQ_ACC_ACK = 4'h8
	} bcsq_access_t;

	typedef enum logic [1:0] {
		BCSQ_HS_BUSY = 2'h0,
		BCSQ_HS_IDLE = 2'h1,
		BCSQ_HS_RETRY = 2'h2,
		BCSQ_HS_WAIT = 2'h3
	} bcsq_hs_t;

	// processor bus pins, strobes active low
	typedef struct packed {
		logic read_not_write;
		logic [1:0] transfer_size;
		logic [1:0] transfer_type;
		logic [2:0] transfer_modifier;
		logic transfer_ack_n;
		logic transfer_error_ack_n;
		logic transfer_start_n;
		logic transfer_in_progress_n;
		logic bus_grant_n;
		logic lock_end_n;
		logic interrupt_pending_n;
	} bcsq_bus_t;

	// decoded view of the captured state
	typedef struct packed {
		bcsq_size_t size;
		bcsq_access_t access;
		bcsq_hs_t handshake;
	} bcsq_class_t;
endpackage : bcsq_pkg

/* File: bcsq_top.sv */
// status word packer and acquisition qualifier generator for a processor bus
// Operation
// - status is a 16-bit word, bit 0 least significant
// - bit 0 is direction: high read, low write
// - bits 1-2 transfer size; 01 byte, 10 word, 00 long, 11 line
// - bits 3-4 carry the transfer type lines unchanged
// - bits 5-7 carry the three transfer modifier lines
// - modifier/type classified into user, supervisor, cache, translation, ack accesses
// - bit 8 follows transfer acknowledge, low when memory responded
// - bit 9 follows transfer error acknowledge, low on failed response
// - bit 10 follows transfer start, low in first cycle of transfer
// - bit 11 follows transfer in progress, low while transfer runs
// - bit 12 follows bus grant, low when mastership granted
// - bit 13 follows lock end, low during last locked transfer
// - bit 14 follows interrupt pending, low once interrupt recognised
// - normal mode: in progress, ack or error ack, and not start
// - mux mode: in progress and any of ack, error ack, start
`timescale 1ns/1ps
module bcsq_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire bcsq_pkg::bcsq_bus_t bus_in,
	input wire bcsq_pkg::bcsq_qmode_t qual_mode,
	output logic [15:0] status_word,
	output logic acquisition_qualifier,
	output bcsq_pkg::bcsq_class_t bus_class
);
	logic [15:0] status_reg;
	logic [15:0] status_next;
	logic qual_reg;
	logic qual_next;
	bcsq_pkg::bcsq_class_t class_reg;
	bcsq_pkg::bcsq_size_t size_next;
	bcsq_pkg::bcsq_access_t access_next;
	bcsq_pkg::bcsq_hs_t handshake_next;
	logic size_byte;
	logic size_word;
	logic size_long;
	logic acc_ack;
	logic acc_user_data;
	logic acc_user_prog;
	logic acc_super_data;
	logic acc_super_prog;
	logic acc_cache_push;
	logic acc_xlat_data;
	logic acc_xlat_prog;
	logic hs_idle;
	logic hs_retry;
	logic hs_wait;

	wire logic ack_low = ~bus_in.transfer_ack_n;
	wire logic err_low = ~bus_in.transfer_error_ack_n;
	wire logic start_low = ~bus_in.transfer_start_n;
	wire logic prog_low = ~bus_in.transfer_in_progress_n;
	wire logic qual_normal = prog_low & (ack_low | err_low) & ~start_low;
	wire logic qual_mux = prog_low & (ack_low | err_low | start_low);
	// codes outside the one-hot set act as normal, so a bad jumper still stores cycles
	wire logic mode_mux = qual_mode == bcsq_pkg::BCSQ_QUAL_MUX;
	wire logic mode_off = qual_mode == bcsq_pkg::BCSQ_QUAL_OFF;
	// modifier lines above type lines, type in the two lowest bits
	wire logic [4:0] mod_type = {bus_in.transfer_modifier, bus_in.transfer_type};
	// in progress, start, error ack, ack from high to low
	wire logic [3:0] handshake_group = {bus_in.transfer_in_progress_n, bus_in.transfer_start_n,
		bus_in.transfer_error_ack_n, bus_in.transfer_ack_n};

	assign qual_next = mode_off ? 1'b0 : (mode_mux ? qual_mux : qual_normal);

	// size pins stay raw in the word; the class carries a local encoding
	bcsq_match #(.W(2), .CARE(2'h3), .MATCH(bcsq_pkg::SIZE_BYTE)) i_size_byte (
		.value(bus_in.transfer_size),
		.hit(size_byte)
	);

	bcsq_match #(.W(2), .CARE(2'h3), .MATCH(bcsq_pkg::SIZE_WORD)) i_size_word (
		.value(bus_in.transfer_size),
		.hit(size_word)
	);

	bcsq_match #(.W(2), .CARE(2'h3), .MATCH(bcsq_pkg::SIZE_LONG)) i_size_long (
		.value(bus_in.transfer_size),
		.hit(size_long)
	);

	// access patterns; a clear care bit is a don't-care position
	bcsq_match #(.W(5), .CARE(5'h03), .MATCH(5'h03)) i_acc_ack (
		.value(mod_type),
		.hit(acc_ack)
	);

	bcsq_match #(.W(5), .CARE(5'h1E), .MATCH(5'h04)) i_acc_user_data (
		.value(mod_type),
		.hit(acc_user_data)
	);

	bcsq_match #(.W(5), .CARE(5'h1F), .MATCH(5'h08)) i_acc_user_prog (
		.value(mod_type),
		.hit(acc_user_prog)
	);

	bcsq_match #(.W(5), .CARE(5'h1E), .MATCH(5'h14)) i_acc_super_data (
		.value(mod_type),
		.hit(acc_super_data)
	);

	bcsq_match #(.W(5), .CARE(5'h1F), .MATCH(5'h18)) i_acc_super_prog (
		.value(mod_type),
		.hit(acc_super_prog)
	);

	bcsq_match #(.W(5), .CARE(5'h1F), .MATCH(5'h00)) i_acc_cache_push (
		.value(mod_type),
		.hit(acc_cache_push)
	);

	bcsq_match #(.W(5), .CARE(5'h1F), .MATCH(5'h0C)) i_acc_xlat_data (
		.value(mod_type),
		.hit(acc_xlat_data)
	);

	bcsq_match #(.W(5), .CARE(5'h1F), .MATCH(5'h10)) i_acc_xlat_prog (
		.value(mod_type),
		.hit(acc_xlat_prog)
	);

	// handshake patterns over the four strobes
	bcsq_match #(.W(4), .CARE(4'h8), .MATCH(4'h8)) i_hs_idle (
		.value(handshake_group),
		.hit(hs_idle)
	);

	bcsq_match #(.W(4), .CARE(4'hB), .MATCH(4'h0)) i_hs_retry (
		.value(handshake_group),
		.hit(hs_retry)
	);

	bcsq_match #(.W(4), .CARE(4'hB), .MATCH(4'h3)) i_hs_wait (
		.value(handshake_group),
		.hit(hs_wait)
	);

	assign size_next = size_byte ? bcsq_pkg::BCSQ_SZ_BYTE :
		size_word ? bcsq_pkg::BCSQ_SZ_WORD :
		size_long ? bcsq_pkg::BCSQ_SZ_LONG :
		bcsq_pkg::BCSQ_SZ_LINE;

	// ack pattern first: it shares no code with the others, so the order only fixes intent
	assign access_next = acc_ack ? bcsq_pkg::BCSQ_ACC_ACK :
		acc_user_data ? bcsq_pkg::BCSQ_ACC_USER_DATA :
		acc_user_prog ? bcsq_pkg::BCSQ_ACC_USER_PROG :
		acc_super_data ? bcsq_pkg::BCSQ_ACC_SUPER_DATA :
		acc_super_prog ? bcsq_pkg::BCSQ_ACC_SUPER_PROG :
		acc_cache_push ? bcsq_pkg::BCSQ_ACC_CACHE_PUSH :
		acc_xlat_data ? bcsq_pkg::BCSQ_ACC_XLAT_DATA :
		acc_xlat_prog ? bcsq_pkg::BCSQ_ACC_XLAT_PROG :
		bcsq_pkg::BCSQ_ACC_OTHER;

	assign handshake_next = hs_idle ? bcsq_pkg::BCSQ_HS_IDLE :
		hs_retry ? bcsq_pkg::BCSQ_HS_RETRY :
		hs_wait ? bcsq_pkg::BCSQ_HS_WAIT :
		bcsq_pkg::BCSQ_HS_BUSY;

	always_comb begin
		status_next = '0;
		status_next[bcsq_pkg::BIT_DIR] = bus_in.read_not_write;
		status_next[bcsq_pkg::BIT_SIZE_LO +: 2] = bus_in.transfer_size;
		status_next[bcsq_pkg::BIT_TYPE_LO +: 2] = bus_in.transfer_type;
		status_next[bcsq_pkg::BIT_MOD_LO +: 3] = bus_in.transfer_modifier;
		status_next[bcsq_pkg::BIT_ACK] = bus_in.transfer_ack_n;
		status_next[bcsq_pkg::BIT_ERR] = bus_in.transfer_error_ack_n;
		status_next[bcsq_pkg::BIT_START] = bus_in.transfer_start_n;
		status_next[bcsq_pkg::BIT_PROG] = bus_in.transfer_in_progress_n;
		status_next[bcsq_pkg::BIT_GRANT] = bus_in.bus_grant_n;
		status_next[bcsq_pkg::BIT_LOCK_END] = bus_in.lock_end_n;
		status_next[bcsq_pkg::BIT_INT_PEND] = bus_in.interrupt_pending_n;
		status_next[bcsq_pkg::BIT_QUAL] = qual_next;
	end

	// one register stage keeps word, qualifier and class aligned to the same bus state
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			// qualifier bit held low so the analyzer stores nothing during reset
			status_reg <= {1'b0, bcsq_pkg::STAT_RESET[14:0]};
			qual_reg <= 1'b0;
			class_reg <= '0;
		end else begin
			status_reg <= status_next;
			qual_reg <= qual_next;
			class_reg.size <= size_next;
			class_reg.access <= access_next;
			class_reg.handshake <= handshake_next;
		end
	end

	assign status_word = status_reg;
	assign acquisition_qualifier = qual_reg;
	assign bus_class = class_reg;
endmodule : bcsq_top

// masked compare: hit when every cared-for bit equals the pattern
module bcsq_match #(
	parameter int W = 5,
	parameter logic [W-1:0] CARE = '1,
	parameter logic [W-1:0] MATCH = '0
) (
	input wire logic [W-1:0] value,
	output logic hit
);
	assign hit = ((value ^ MATCH) & CARE) == '0;
endmodule : bcsq_match

/* File: bcsq_top_assertions.sv */
// checker: status word packing and qualifier timing at the top ports
`timescale 1ns/1ps
module bcsq_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire bcsq_pkg::bcsq_bus_t bus_in,
	input wire bcsq_pkg::bcsq_qmode_t qual_mode,
	input wire logic [15:0] status_word,
	input wire logic acquisition_qualifier,
	input wire bcsq_pkg::bcsq_class_t bus_class
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire logic prog_n = bus_in.transfer_in_progress_n;
	wire logic any_ack = !bus_in.transfer_ack_n || !bus_in.transfer_error_ack_n;
	wire logic norm_hit = !prog_n && any_ack && bus_in.transfer_start_n;
	wire logic mux_hit = !prog_n && (any_ack || !bus_in.transfer_start_n);
	wire logic mode_bad = !(qual_mode inside {bcsq_pkg::BCSQ_QUAL_NORMAL,
		bcsq_pkg::BCSQ_QUAL_MUX, bcsq_pkg::BCSQ_QUAL_OFF});
	wire logic [6:0] strobes = {<<{bus_in[6:0]}};
	wire logic [7:0] head = {bus_in[9:7], bus_in[11:10], bus_in[13:12], bus_in[14]};
	sequence s_retry;
		!prog_n && !bus_in.transfer_error_ack_n && !bus_in.transfer_ack_n;
	endsequence
	head_map_a: assert property ($past(rst_n) |-> status_word[7:0] == $past(head))
		else $error("status low byte wrong");
	strobe_map_a: assert property (rst_n |=> status_word[14:8] == $past(strobes))
		else $error("status strobes wrong");
	qual_bit_a: assert property (status_word[15] == acquisition_qualifier)
		else $error("qualifier bit differs");
	qual_norm_a: assert property (qual_mode == bcsq_pkg::BCSQ_QUAL_NORMAL |=> acquisition_qualifier == $past(norm_hit))
		else $error("normal qualifier wrong");
	qual_mux_a: assert property (qual_mode == bcsq_pkg::BCSQ_QUAL_MUX |=> acquisition_qualifier == $past(mux_hit))
		else $error("mux qualifier wrong");
	qual_off_a: assert property (qual_mode == bcsq_pkg::BCSQ_QUAL_OFF |=> !acquisition_qualifier)
		else $error("qualifier not off");
	qual_dflt_a: assert property (mode_bad |=> acquisition_qualifier == $past(norm_hit))
		else $error("illegal mode not normal");
	ack_class_a: assert property (bus_in.transfer_type == 2'h3 |=> bus_class.access == bcsq_pkg::BCSQ_ACC_ACK)
		else $error("ack access not seen");
	hs_retry_a: assert property (s_retry |=> bus_class.handshake == bcsq_pkg::BCSQ_HS_RETRY)
		else $error("retry not seen");
	size_byte_a: assert property (bus_in.transfer_size == 2'h1 |=> bus_class.size == bcsq_pkg::BCSQ_SZ_BYTE)
		else $error("byte size not seen");
endmodule : bcsq_checker
bind bcsq_top bcsq_checker i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .bus_in(bus_in),
	.qual_mode(qual_mode), .status_word(status_word),
	.acquisition_qualifier(acquisition_qualifier), .bus_class(bus_class));

/* File: bcsq_top_tb.sv */
// testbench: random bus traffic against an integer model of the status word
`timescale 1ns/1ps
module bcsq_top_tb;
	localparam bcsq_pkg::bcsq_qmode_t MODES[4] = '{bcsq_pkg::BCSQ_QUAL_NORMAL,
		bcsq_pkg::BCSQ_QUAL_MUX, bcsq_pkg::BCSQ_QUAL_OFF, bcsq_pkg::bcsq_qmode_t'(3'h0)};
	localparam int SZT[4] = '{2, 0, 1, 3};
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	bcsq_pkg::bcsq_bus_t bus_in = '0;
	bcsq_pkg::bcsq_qmode_t qual_mode = bcsq_pkg::BCSQ_QUAL_NORMAL;
	logic [15:0] status_word;
	logic acquisition_qualifier;
	bcsq_pkg::bcsq_class_t bus_class;
	int stored;
	int errors = 0;
	int check_count = 0;
	int hits = 0;
	int exp_q[$];
	logic [31:0] seed = 32'h000025EF;
	always #2.5 clk_sys = ~clk_sys;
	bcsq_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_in(bus_in), .qual_mode(qual_mode),
		.status_word(status_word), .acquisition_qualifier(acquisition_qualifier),
		.bus_class(bus_class));
	bcsq_analyzer_model i_ana (.clk_sys(clk_sys), .rst_n(rst_n), .status_word(status_word),
		.stored(stored));
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	function automatic int model(input bcsq_pkg::bcsq_bus_t b, input bcsq_pkg::bcsq_qmode_t m);
		int mt, acc, hs, q, ak, sz;
		logic [6:0] st;
		st = {<<{b[6:0]}};
		mt = {b.transfer_modifier, b.transfer_type};
		ak = !b.transfer_ack_n || !b.transfer_error_ack_n;
		q = (m == bcsq_pkg::BCSQ_QUAL_MUX) ? ak || !b.transfer_start_n : ak && b.transfer_start_n;
		q = (m == bcsq_pkg::BCSQ_QUAL_OFF) ? 0 : q && !b.transfer_in_progress_n;
		sz = SZT[b.transfer_size];
		case (mt)
			5'h04, 5'h05: acc = 1;
			5'h08: acc = 2;
			5'h14, 5'h15: acc = 3;
			5'h18: acc = 4;
			5'h00: acc = 5;
			5'h0C: acc = 6;
			5'h10: acc = 7;
			default: acc = 0;
		endcase
		if (b.transfer_type == 2'h3) acc = 8;
		hs = (b.transfer_ack_n == b.transfer_error_ack_n) ? 2 + b.transfer_ack_n : 0;
		if (b.transfer_in_progress_n) hs = 1;
		return {sz[1:0], acc[3:0], hs[1:0], q[0], st, b[9:7], b[11:10], b[13:12], b[14]};
	endfunction : model
	task check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task results;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	initial begin : watchdog
		#40000;
		errors++;
		results();
	end
	initial begin : main
		int e;
		repeat (5) @(posedge clk_sys);
		#1 check("reset", {bus_class, status_word}, 24'h007FFF);
		@(posedge clk_sys) rst_n <= 1'b1;
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk_sys);
			seed = xorshift(seed);
			bus_in <= bcsq_pkg::bcsq_bus_t'(seed[14:0]);
			qual_mode <= MODES[seed[17:16]];
			#1;
			if (exp_q.size() > 0) begin
				e = exp_q.pop_front();
				check("outputs", {bus_class, status_word}, e[23:0]);
				hits += e[15];
			end
			exp_q.push_back(model(bcsq_pkg::bcsq_bus_t'(seed[14:0]), MODES[seed[17:16]]));
		end
		@(posedge clk_sys);
		#1 check("stored", stored[23:0], hits[23:0]);
		results();
	end
endmodule : bcsq_top_tb
